// ### logic/pmic_pkg.sv
// Purpose: Shared constants, types and helpers for the pending/mask interrupt controller.
// Assumes: One system clock; 32 source lines after sub-request merging.
// Notes:   Seven arbiters: six first-level groups plus one second-level arbiter.
package pmic_pkg;

   localparam int unsigned PMIC_NUM_SRC   = 32;
   localparam int unsigned PMIC_NUM_GROUP = 6;
   localparam int unsigned PMIC_NUM_ARB   = 7;
   localparam int unsigned PMIC_ARB_REQS  = 6;
   localparam int unsigned PMIC_TOP_ARB   = 6;

   // Values after reset.
   localparam logic [31:0] PMIC_SRC_PEND_RST = 32'h0000_0000;
   localparam logic [31:0] PMIC_WIN_PEND_RST = 32'h0000_0000;
   localparam logic [31:0] PMIC_MASK_RST     = 32'hffff_ffff;
   localparam logic [31:0] PMIC_FAST_SEL_RST = 32'h0000_0000;
   localparam logic [13:0] PMIC_ORDER_RST    = 14'h0000;
   localparam logic [6:0]  PMIC_ROTATE_RST   = 7'h00;

   // Positions of the merged source lines.
   localparam int unsigned PMIC_BIT_EXT_4_7  = 4;
   localparam int unsigned PMIC_BIT_EXT_8_23 = 5;
   localparam int unsigned PMIC_BIT_CAMERA   = 6;
   localparam int unsigned PMIC_BIT_SERIAL2  = 15;
   localparam int unsigned PMIC_BIT_SERIAL1  = 23;
   localparam int unsigned PMIC_BIT_SERIAL0  = 28;
   localparam int unsigned PMIC_BIT_ADC      = 31;

   typedef enum logic [1:0] {
      PMIC_HEAD_REQ1 = 2'b00,
      PMIC_HEAD_REQ2 = 2'b01,
      PMIC_HEAD_REQ3 = 2'b10,
      PMIC_HEAD_REQ4 = 2'b11
   } pmic_sel_t;

   // Raw sub-requests that are OR-merged into single source lines.
   typedef struct packed {
      logic [23:0] external_pin_request;
      logic [1:0]  camera_capture;
      logic [1:0]  adc_conv_touch;
      logic [2:0]  serial_port_request0;
      logic [2:0]  serial_port_request1;
      logic [2:0]  serial_port_request2;
   } pmic_sub_req_t;

   // Software write strobes and data for the controller registers.
   typedef struct packed {
      logic        mask_we;
      logic [31:0] mask_data;
      logic        fast_sel_we;
      logic [31:0] fast_sel_data;
      logic        prio_we;
      logic [6:0]  rotate_data;
      logic [13:0] order_data;
      logic        src_clear_we;
      logic [31:0] src_clear_data;
      logic        win_clear_we;
      logic [31:0] win_clear_data;
   } pmic_sw_cmd_t;

   // First source bit of each first-level group.
   function automatic logic [4:0] pmic_group_base(input int unsigned g);
      case (g)
         0:       pmic_group_base = 5'h00;
         1:       pmic_group_base = 5'h04;
         2:       pmic_group_base = 5'h0a;
         3:       pmic_group_base = 5'h10;
         4:       pmic_group_base = 5'h16;
         default: pmic_group_base = 5'h1c;
      endcase
   endfunction

   // Number of sources wired into each first-level group.
   function automatic logic [2:0] pmic_group_size(input int unsigned g);
      case (g)
         0:       pmic_group_size = 3'h4;
         5:       pmic_group_size = 3'h4;
         default: pmic_group_size = 3'h6;
      endcase
   endfunction

endpackage

// ### logic/pmic_arbiter.sv
// Purpose: Six-input arbiter with rotatable middle priority.
// Assumes: Purely combinational; the caller holds the order select.
// Notes:   Input 0 always wins first, input 5 always last.
`timescale 1ns/100ps
`default_nettype none
module pmic_arbiter (
   // Requests.
   input  wire logic [5:0]         req_i,
   input  wire pmic_pkg::pmic_sel_t sel_i,
   // Grant.
   output logic                    grant_any_o,
   output logic [2:0]              grant_idx_o
);
   import pmic_pkg::*;

   logic [2:0] cand;

   always_comb begin
      grant_any_o = |req_i;
      grant_idx_o = 3'h0;
      cand        = 3'h0;
      if (req_i[0]) begin
         grant_idx_o = 3'h0;
      end else if (|req_i[4:1]) begin
         for (int k = 3; k >= 0; k--) begin
            cand = 3'h1 + {1'b0, 2'(sel_i + 2'(k))};
            if (req_i[cand]) begin
               grant_idx_o = cand;
            end
         end
      end else begin
         grant_idx_o = 3'h5;
      end
   end

endmodule // pmic_arbiter
`default_nettype wire

// ### logic/pmic_ctrl.sv
// Purpose: Interrupt controller with source pending, mask, mode and winner pending.
// Assumes: Inputs synchronous to clock_i; software access by plain strobe ports.
// Notes:   Request lines are levels held while a winner bit of that mode is set.
//
// Summary of operation
// - Accept fifty-eight raw sources into thirty-two lines.
// - OR serial and pin sub-requests per line.
// - Arbitrate first, then drive fast or normal.
// - Winner recorded so software sees its source.
// - Per-source mode picks fast or normal line.
// - Any source request sets its pending bit.
// - One winner bit set with pending update.
// - Masked source pends but never wins.
// - Both pending registers clear by writing one.
// - Mask one blocks servicing; pending still set.
// - Groups zero to two take listed sources.
// - Groups three to five take listed sources.
// - Camera, ADC and serial ports merge sub-requests.
// - Six first-level arbiters feed one second-level.
// - Input zero first, five last, middle rotates.
// - Rotation reloads order select after servicing.
`timescale 1ns/100ps
`default_nettype none
module pmic_ctrl (
   // Clock and reset.
   input  wire logic                    clock_i,
   input  wire logic                    reset_n_i,
   // Interrupt sources.
   input  wire logic [31:0]             peripheral_req_i,
   input  wire pmic_pkg::pmic_sub_req_t sub_req_i,
   // Software register writes.
   input  wire pmic_pkg::pmic_sw_cmd_t  sw_cmd_i,
   // Register state.
   output logic [31:0]                  source_pending_o,
   output logic [31:0]                  winner_pending_o,
   output logic [31:0]                  source_mask_o,
   output logic [31:0]                  fast_select_o,
   output logic [6:0]                   arbiter_rotate_enable_o,
   output logic [13:0]                  arbiter_order_select_o,
   output logic [4:0]                   winner_offset_o,
   // Requests to the core.
   output logic                         fast_request_o,
   output logic                         normal_request_o
);
   import pmic_pkg::*;

   logic [31:0] source_pending_reg;
   logic [31:0] source_pending_next;
   logic [31:0] winner_pending_reg;
   logic [31:0] winner_pending_next;
   logic [31:0] source_mask_reg;
   logic [31:0] fast_select_reg;
   logic [31:0] fast_select_next;
   logic [6:0]  arbiter_rotate_enable_reg;
   logic [13:0] arbiter_order_select_reg;
   logic [13:0] arbiter_order_select_next;
   logic [4:0]  winner_offset_reg;
   logic        fast_request_reg;
   logic        normal_request_reg;
   logic        fast_level;
   logic        normal_level;

   logic [31:0] source_line;
   logic [31:0] arb_in;
   logic [5:0]  group_req [PMIC_NUM_GROUP];
   logic        group_any [PMIC_NUM_GROUP];
   logic [2:0]  group_idx [PMIC_NUM_GROUP];
   logic [5:0]  top_req;
   logic        top_any;
   logic [2:0]  top_idx;
   logic        win_set;
   logic [4:0]  win_bit;

   // New rotation value after an arbiter input has been serviced.
   function automatic logic [1:0] rotate_next(input logic [1:0] sel, input logic [2:0] idx);
      case (idx)
         3'h1:    rotate_next = PMIC_HEAD_REQ2;
         3'h2:    rotate_next = PMIC_HEAD_REQ3;
         3'h3:    rotate_next = PMIC_HEAD_REQ4;
         3'h4:    rotate_next = PMIC_HEAD_REQ1;
         default: rotate_next = sel;
      endcase
   endfunction

   // Merge sub-requests into the single source lines.
   always_comb begin
      // Pins zero to three each keep a line of their own.
      source_line                    = peripheral_req_i;
      source_line[3:0]               = sub_req_i.external_pin_request[3:0];
      source_line[PMIC_BIT_EXT_4_7]  = |sub_req_i.external_pin_request[7:4];
      source_line[PMIC_BIT_EXT_8_23] = |sub_req_i.external_pin_request[23:8];
      source_line[PMIC_BIT_CAMERA]   = |sub_req_i.camera_capture;
      source_line[PMIC_BIT_ADC]      = |sub_req_i.adc_conv_touch;
      source_line[PMIC_BIT_SERIAL0]  = |sub_req_i.serial_port_request0;
      source_line[PMIC_BIT_SERIAL1]  = |sub_req_i.serial_port_request1;
      source_line[PMIC_BIT_SERIAL2]  = |sub_req_i.serial_port_request2;
   end

   // Source pending: a new request wins over a write-one clear.
   // A request that arrives during a clear is therefore never lost.
   always_comb begin
      source_pending_next = source_pending_reg;
      if (sw_cmd_i.src_clear_we) begin
         source_pending_next = source_pending_next & ~sw_cmd_i.src_clear_data;
      end
      source_pending_next = source_pending_next | source_line;
   end

   // Only unmasked pending sources take part in arbitration.
   assign arb_in = source_pending_next & ~source_mask_reg;

   // Slice the unmasked lines into the six first-level groups.
   // Group bases and sizes come from the package helpers.
   always_comb begin
      for (int g = 0; g < PMIC_NUM_GROUP; g++) begin
         group_req[g] = 6'h00;
         for (int j = 0; j < PMIC_ARB_REQS; j++) begin
            if (3'(j) < pmic_group_size(g)) begin
               group_req[g][j] = arb_in[5'(pmic_group_base(g) + 5'(j))];
            end
         end
      end
   end

   // First-level arbiters, one per source group.
   for (genvar g = 0; g < PMIC_NUM_GROUP; g++) begin : g_first_level
      pmic_arbiter u_arb (
         .req_i       (group_req[g]),
         .sel_i       (pmic_sel_t'(arbiter_order_select_reg[2*g +: 2])),
         .grant_any_o (group_any[g]),
         .grant_idx_o (group_idx[g])
      );
   end

   // Each group that holds a request feeds the second-level arbiter.
   always_comb begin
      for (int g = 0; g < PMIC_NUM_GROUP; g++) begin
         top_req[g] = group_any[g];
      end
   end

   // Second-level arbiter picks the winning group.
   pmic_arbiter u_arb_top (
      .req_i       (top_req),
      .sel_i       (pmic_sel_t'(arbiter_order_select_reg[2*PMIC_TOP_ARB +: 2])),
      .grant_any_o (top_any),
      .grant_idx_o (top_idx)
   );

   // A winner is taken only while no winner bit is outstanding.
   // This keeps the winner register one-hot and the request level steady.
   always_comb begin
      win_set = top_any && (winner_pending_reg == 32'h0000_0000);
      win_bit = 5'h00;
      for (int g = 0; g < PMIC_NUM_GROUP; g++) begin
         if (top_idx == 3'(g)) begin
            win_bit = pmic_group_base(g) + {2'b00, group_idx[g]};
         end
      end
   end

   // Winner pending: write-one clear, then the new winner bit.
   always_comb begin
      winner_pending_next = winner_pending_reg;
      if (sw_cmd_i.win_clear_we) begin
         winner_pending_next = winner_pending_next & ~sw_cmd_i.win_clear_data;
      end
      if (win_set) begin
         winner_pending_next = winner_pending_next | (32'h0000_0001 << win_bit);
      end
   end

   // Order select: software write, then rotation of serviced arbiters.
   // Rotation wins over a priority write to the same slice.
   always_comb begin
      arbiter_order_select_next = arbiter_order_select_reg;
      if (sw_cmd_i.prio_we) begin
         arbiter_order_select_next = sw_cmd_i.order_data;
      end
      if (win_set) begin
         for (int a = 0; a < PMIC_NUM_GROUP; a++) begin
            if (top_idx == 3'(a) && arbiter_rotate_enable_reg[a]) begin
               arbiter_order_select_next[2*a +: 2] =
                  rotate_next(arbiter_order_select_reg[2*a +: 2], group_idx[a]);
            end
         end
         if (arbiter_rotate_enable_reg[PMIC_TOP_ARB]) begin
            arbiter_order_select_next[2*PMIC_TOP_ARB +: 2] =
               rotate_next(arbiter_order_select_reg[2*PMIC_TOP_ARB +: 2], top_idx);
         end
      end
   end

   // Mode bits as they stand after this edge.
   always_comb begin
      fast_select_next = fast_select_reg;
      if (sw_cmd_i.fast_sel_we) begin
         fast_select_next = sw_cmd_i.fast_sel_data;
      end
   end

   // Request levels from the next winner and mode bits, so they never lag.
   always_comb begin
      fast_level   = |(winner_pending_next & fast_select_next);
      normal_level = |(winner_pending_next & ~fast_select_next);
   end

   // Source pending register.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         source_pending_reg <= PMIC_SRC_PEND_RST;
      end else begin
         source_pending_reg <= source_pending_next;
      end
   end

   // Winner pending register.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         winner_pending_reg <= PMIC_WIN_PEND_RST;
      end else begin
         winner_pending_reg <= winner_pending_next;
      end
   end

   // Offset of the last winner, held until the next one is taken.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         winner_offset_reg <= 5'h00;
      end else if (win_set) begin
         winner_offset_reg <= win_bit;
      end
   end

   // Source mask register.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         source_mask_reg <= PMIC_MASK_RST;
      end else if (sw_cmd_i.mask_we) begin
         source_mask_reg <= sw_cmd_i.mask_data;
      end
   end

   // Mode register: a one selects the fast line.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fast_select_reg <= PMIC_FAST_SEL_RST;
      end else if (sw_cmd_i.fast_sel_we) begin
         fast_select_reg <= sw_cmd_i.fast_sel_data;
      end
   end

   // Rotation enables change only by a priority write.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arbiter_rotate_enable_reg <= PMIC_ROTATE_RST;
      end else if (sw_cmd_i.prio_we) begin
         arbiter_rotate_enable_reg <= sw_cmd_i.rotate_data;
      end
   end

   // Order select register.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arbiter_order_select_reg <= PMIC_ORDER_RST;
      end else begin
         arbiter_order_select_reg <= arbiter_order_select_next;
      end
   end

   // Fast request line to the core.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fast_request_reg <= 1'b0;
      end else begin
         fast_request_reg <= fast_level;
      end
   end

   // Normal request line to the core.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         normal_request_reg <= 1'b0;
      end else begin
         normal_request_reg <= normal_level;
      end
   end

   // Every output comes straight from its register.
   assign source_pending_o        = source_pending_reg;
   assign winner_pending_o        = winner_pending_reg;
   assign source_mask_o           = source_mask_reg;
   assign fast_select_o           = fast_select_reg;
   assign arbiter_rotate_enable_o = arbiter_rotate_enable_reg;
   assign arbiter_order_select_o  = arbiter_order_select_reg;
   assign winner_offset_o         = winner_offset_reg;
   assign fast_request_o          = fast_request_reg;
   assign normal_request_o        = normal_request_reg;

endmodule // pmic_ctrl
`default_nettype wire

// ### test/pmic_ctrl_asserts.sv
// Purpose: Concurrent checks on the interrupt controller ports.
// Assumes: One clock domain; reset is active low.
// Notes:   Bound to every instance of the controller.
`timescale 1ns/100ps
`default_nettype none
module pmic_ctrl_asserts (
   // Clock and reset.
   input wire logic                    clock_i,
   input wire logic                    reset_n_i,
   // Inputs.
   input wire logic [31:0]             peripheral_req_i,
   input wire pmic_pkg::pmic_sub_req_t sub_req_i,
   input wire pmic_pkg::pmic_sw_cmd_t  sw_cmd_i,
   // Outputs.
   input wire logic [31:0]             source_pending_o,
   input wire logic [31:0]             winner_pending_o,
   input wire logic [31:0]             source_mask_o,
   input wire logic [31:0]             fast_select_o,
   input wire logic [6:0]              arbiter_rotate_enable_o,
   input wire logic [13:0]             arbiter_order_select_o,
   input wire logic [4:0]              winner_offset_o,
   input wire logic                    fast_request_o,
   input wire logic                    normal_request_o
);
   import pmic_pkg::*;
   localparam logic [31:0] KEEP = 32'h6f7f_7f80;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_win_new;
      winner_pending_o == 32'h0 ##1 winner_pending_o != 32'h0;
   endsequence
   sequence s_win_held;
      winner_pending_o != 32'h0 && !sw_cmd_i.win_clear_we;
   endsequence
   a_winner_onehot: assert property ($onehot0(winner_pending_o))
      else $error("More than one winner bit.");
   a_winner_source: assert property (s_win_new |->
      (winner_pending_o & source_pending_o) != 0)
      else $error("Winner without pending source.");
   a_winner_masked: assert property (s_win_new |->
      (winner_pending_o & $past(source_mask_o)) == 0)
      else $error("Masked source won.");
   a_offset_match: assert property (s_win_new |->
      winner_pending_o == 32'h1 << winner_offset_o)
      else $error("Offset differs from winner.");
   a_winner_held: assert property (s_win_held |=> $stable(winner_pending_o))
      else $error("Winner changed while pending.");
   a_win_clear: assert property (sw_cmd_i.win_clear_we && winner_pending_o != 0 |=>
      (winner_pending_o & $past(sw_cmd_i.win_clear_data)) == 0)
      else $error("Winner bit not cleared.");
   a_src_set: assert property ((peripheral_req_i & KEEP) != 0 |=>
      (source_pending_o & $past(peripheral_req_i) & KEEP) == ($past(peripheral_req_i) & KEEP))
      else $error("Source pending not set.");
   a_src_clear: assert property (sw_cmd_i.src_clear_we |=>
      (source_pending_o & $past(sw_cmd_i.src_clear_data & ~peripheral_req_i) & KEEP) == 0)
      else $error("Source pending not cleared.");
   a_serial_merge: assert property (|sub_req_i.serial_port_request0 |=>
      source_pending_o[28])
      else $error("Serial line not merged.");
   a_pin_merge: assert property (|sub_req_i.external_pin_request[23:8] |=>
      source_pending_o[5])
      else $error("Pin group not merged.");
   a_fast_level: assert property (fast_request_o == |(winner_pending_o & fast_select_o))
      else $error("Fast request level wrong.");
   a_normal_level: assert property (
      normal_request_o == |(winner_pending_o & ~fast_select_o))
      else $error("Normal request level wrong.");
   a_fixed_order: assert property (!sw_cmd_i.prio_we &&
      arbiter_rotate_enable_o == 7'h00 |=> $stable(arbiter_order_select_o))
      else $error("Order changed in fixed mode.");
endmodule // pmic_ctrl_asserts
bind pmic_ctrl pmic_ctrl_asserts u_asserts (.clock_i, .reset_n_i, .peripheral_req_i,
   .sub_req_i, .sw_cmd_i, .source_pending_o, .winner_pending_o, .source_mask_o, .fast_select_o,
   .arbiter_rotate_enable_o, .arbiter_order_select_o, .winner_offset_o, .fast_request_o,
   .normal_request_o);
`default_nettype wire

// ### test/pmic_core_model.sv
// Purpose: Processor core that takes fast and normal requests.
// Assumes: Requests are levels; latency sets how slowly it answers.
// Notes:   Take stays high while the request is honoured.
`timescale 1ns/100ps
`default_nettype none
module pmic_core_model (
   // Clock and reset.
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   // Requests, disable flags and latency.
   input  wire logic       fast_request_i,
   input  wire logic       normal_request_i,
   input  wire logic       fast_disable_i,
   input  wire logic       normal_disable_i,
   input  wire logic [3:0] latency_i,
   // Request taken.
   output logic            take_o
);
   logic [3:0] wait_reg;
   logic       want;
   assign want = (fast_request_i & ~fast_disable_i) |
                 (normal_request_i & ~normal_disable_i);
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_reg <= 4'h0;
         take_o <= 1'b0;
      end else begin
         take_o <= want && wait_reg >= latency_i;
         wait_reg <= want ? wait_reg + 4'(wait_reg != 4'hf) : 4'h0;
      end
   end
endmodule // pmic_core_model
`default_nettype wire

// ### test/pmic_ctrl_tb.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: A cycle model is compared with every output each cycle.
// Notes:   Configuration is written only in quiet cycles.
`timescale 1ns/100ps
`default_nettype none
module pmic_ctrl_tb;
   import pmic_pkg::*;
   localparam int BASE [6] = '{0, 4, 10, 16, 22, 28};
   logic          clock_i, reset_n_i, take, fdis, ndis, fast_request_o, normal_request_o;
   logic [31:0]   peripheral_req_i, source_pending_o, winner_pending_o, source_mask_o;
   logic [31:0]   fast_select_o, m_src, m_win, m_mask, m_fsel;
   pmic_sub_req_t sub_req_i;
   pmic_sw_cmd_t  sw_cmd_i;
   logic [6:0]    arbiter_rotate_enable_o, m_rot;
   logic [13:0]   arbiter_order_select_o, m_ord;
   logic [4:0]    winner_offset_o, m_off;
   logic [3:0]    lat;
   int            n_errors, num_checks;
   pmic_ctrl u_dut (.clock_i, .reset_n_i, .peripheral_req_i, .sub_req_i, .sw_cmd_i,
      .source_pending_o, .winner_pending_o, .source_mask_o, .fast_select_o,
      .arbiter_rotate_enable_o, .arbiter_order_select_o, .winner_offset_o,
      .fast_request_o, .normal_request_o);
   pmic_core_model u_core (.clock_i, .reset_n_i, .fast_request_i(fast_request_o),
      .normal_request_i(normal_request_o), .fast_disable_i(fdis), .normal_disable_i(ndis),
      .latency_i(lat), .take_o(take));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   function automatic int arb(input logic [5:0] r, input logic [1:0] s);
      if (r[0]) return 0;
      for (int k = 0; k < 4; k++) if (r[1 + (s + k) % 4]) return 1 + (s + k) % 4;
      return r[5] ? 5 : -1;
   endfunction
   task automatic step();
      logic [31:0] m;
      logic [31:0] cand;
      logic [5:0]  hit;
      int          gi [6];
      int          t;
      logic [13:0] o;
      logic [6:0]  rt;
      {rt, o} = {m_rot, m_ord};
      if (sw_cmd_i.prio_we) {m_rot, m_ord} = {sw_cmd_i.rotate_data, sw_cmd_i.order_data};
      m = peripheral_req_i & 32'h6f7f_7f80;
      m[3:0] = sub_req_i.external_pin_request[3:0];
      m[4] = |sub_req_i.external_pin_request[7:4];
      m[5] = |sub_req_i.external_pin_request[23:8];
      m[6] = |sub_req_i.camera_capture;
      m[15] = |sub_req_i.serial_port_request2;
      m[23] = |sub_req_i.serial_port_request1;
      m[28] = |sub_req_i.serial_port_request0;
      m[31] = |sub_req_i.adc_conv_touch;
      m = m | m_src & ~(sw_cmd_i.src_clear_we ? sw_cmd_i.src_clear_data : 32'h0);
      cand = m & ~m_mask;
      if (m_win == 32'h0 && cand != 32'h0) begin
         for (int g = 0; g < 6; g++) begin
            gi[g] = arb(6'(cand >> BASE[g]) & (g % 5 == 0 ? 6'h0f : 6'h3f), o[2*g +: 2]);
            hit[g] = gi[g] >= 0;
         end
         t = arb(hit, o[13:12]);
         m_off = 5'(BASE[t] + gi[t]);
         m_win = 32'h1 << m_off;
         if (rt[t] && gi[t] inside {[1:4]}) m_ord[2*t +: 2] = 2'(gi[t]);
         if (rt[6] && t inside {[1:4]}) m_ord[13:12] = 2'(t);
      end else if (sw_cmd_i.win_clear_we) m_win &= ~sw_cmd_i.win_clear_data;
      if (sw_cmd_i.mask_we) m_mask = sw_cmd_i.mask_data;
      if (sw_cmd_i.fast_sel_we) m_fsel = sw_cmd_i.fast_sel_data;
      m_src = m;
   endtask
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {m_src, m_win, m_fsel, m_rot, m_ord, m_off} = '0;
         m_mask = 32'hffff_ffff;
      end else begin
         step();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   always @(negedge clock_i) begin
      if (reset_n_i) begin
         chk(source_pending_o, m_src);
         chk(winner_pending_o, m_win);
         chk(source_mask_o, m_mask);
         chk(fast_select_o, m_fsel);
         chk({arbiter_rotate_enable_o, arbiter_order_select_o, winner_offset_o},
             {m_rot, m_ord, m_off});
         chk(fast_request_o, |(m_win & m_fsel));
         chk(normal_request_o, |(m_win & ~m_fsel));
      end
   end
   task automatic drive(input logic [31:0] p, input pmic_sub_req_t s, input pmic_sw_cmd_t c);
      @(posedge clock_i);
      #1;
      peripheral_req_i = p;
      sub_req_i = s;
      sw_cmd_i = c;
   endtask
   task automatic burst(input pmic_sw_cmd_t c);
      drive($urandom & $urandom & $urandom, pmic_sub_req_t'(37'({$urandom, $urandom}
         & {$urandom, $urandom} & {$urandom, $urandom})), c);
   endtask
   task automatic cfg(input logic [31:0] mk, input logic [31:0] fs, input logic [6:0] rt,
                      input logic [13:0] od);
      pmic_sw_cmd_t c;
      c = '0;
      {c.src_clear_we, c.src_clear_data, c.win_clear_we, c.win_clear_data} = '1;
      drive('0, '0, c);
      c = '0;
      {c.mask_we, c.mask_data, c.fast_sel_we, c.fast_sel_data} = {1'b1, mk, 1'b1, fs};
      {c.prio_we, c.rotate_data, c.order_data} = {1'b1, rt, od};
      drive('0, '0, c);
      drive('0, '0, '0);
   endtask
   task automatic service(input int rounds, input string name);
      pmic_sw_cmd_t c;
      int           w;
      for (int r = 0; r < rounds; r++) begin
         lat = 4'($urandom % 6);
         burst('0);
         drive('0, '0, '0);
         for (w = 0; m_win != 32'h0 && take !== 1'b1 && w < 40; w++) drive('0, '0, '0);
         if (w == 40) chk(32'h0, 32'h1);
         if (m_win != 32'h0) begin
            c = '0;
            {c.src_clear_we, c.src_clear_data} = {1'b1, m_win};
            burst(c);
            c = '0;
            {c.win_clear_we, c.win_clear_data} = {1'b1, m_win};
            drive('0, '0, c);
         end
      end
      $display("test %s done, %0d mismatches so far", name, n_errors);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(16273));
      {n_errors, num_checks, fdis, ndis, lat, reset_n_i} = '0;
      {peripheral_req_i, sub_req_i, sw_cmd_i} = '0;
      repeat (16) @(posedge clock_i);
      #1;
      reset_n_i = 1'b1;
      service(20, "masked");
      for (int s = 0; s < 4; s++) begin
         cfg(32'h0, 32'h0, 7'h00, {7{2'(s)}});
         service(30, "fixed");
      end
      cfg(32'h0, 32'h0, 7'h7f, 14'($urandom));
      service(150, "rotate");
      cfg(32'h0, 32'h1 << ($urandom % 32), 7'h7f, 14'h0);
      service(80, "fast");
      cfg($urandom, 32'h0, 7'($urandom), 14'($urandom));
      service(80, "mask");
      cfg(32'h0, 32'h0, 7'h00, 14'h0);
      {fdis, ndis} = 2'b11;
      drive(32'h0000_0100, '0, '0);
      repeat (10) begin
         drive('0, '0, '0);
         chk(take, 1'b0);
      end
      {fdis, ndis} = 2'b00;
      service(5, "disable");
      summarize();
   end
   initial begin
      #500000;
      n_errors++;
      summarize();
   end
endmodule // pmic_ctrl_tb
`default_nettype wire
